// ### hw/cdg_chan_apply.sv
`timescale 1ns/1ps
`default_nettype none
`include "cdg_defines.svh"
// turns one channel's codes into the applied gain and offset
module cdg_chan_apply (
  input wire logic pclk,     // bus clock
  input wire logic presetn,  // async reset, active low
  cdg_chan_if.app  chan      // settings in, results out
);
  cdg_pkg::cdg_app_state_type state;       // registered state
  cdg_pkg::cdg_app_state_type next_state;  // next value

  // gain and offset pass only while their global apply bit is set
  always_comb begin
    next_state = state;
    // gain is code times the 0.2 dB step
    next_state.gain_tenths = chan.gain_en ?
      6'(chan.gain_code * `CDG_GAIN_STEP_TENTHS) : 6'h00;
    // primary copy is used; a disagreeing copy is only flagged
    next_state.offset = chan.off_en ? chan.off_prim : `CDG_RESET_OFFSET;
    next_state.mismatch = (chan.off_prim != chan.off_copy);
  end

  // state register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  assign chan.gain_tenths = state.gain_tenths;
  assign chan.offset      = state.offset;
  assign chan.mismatch    = state.mismatch;

  // applied gain follows code one cycle later
  chk_gain_scale: assert property (@(posedge pclk) disable iff (!presetn)
    ##1 chan.gain_tenths == ($past(chan.gain_en) ? 6'($past(chan.gain_code) * 2) : 6'h00))
    else $error("applied gain wrong");
  // gain held at zero while gain apply is off
  chk_gain_gate: assert property (@(posedge pclk) disable iff (!presetn)
    !chan.gain_en [*2] |-> chan.gain_tenths == 6'h00)
    else $error("gain applied while disabled");
  // offset keeps its sign bits unchanged
  chk_offset_sign: assert property (@(posedge pclk) disable iff (!presetn)
    chan.off_en |=> $signed(chan.offset) == $signed($past(chan.off_prim)))
    else $error("offset value changed");
  // offset zero while offset apply is off
  chk_offset_gate: assert property (@(posedge pclk) disable iff (!presetn)
    !chan.off_en |=> chan.offset == 10'h000)
    else $error("offset applied while disabled");
  cov_both_on: cover property (@(posedge pclk) disable iff (!presetn)
    chan.gain_en && chan.off_en && chan.gain_code == 5'h1f);
endmodule // cdg_chan_apply
`default_nettype wire

// ### hw/cdg_chan_if.sv
`timescale 1ns/1ps
`default_nettype none
// carries one channel's settings to its apply stage and the results back
interface cdg_chan_if;
  logic       [4:0] gain_code;    // programmed gain code
  logic       [9:0] off_prim;     // offset from the primary register
  logic       [9:0] off_copy;     // offset from the copy register
  logic             gain_en;      // global gain apply
  logic             off_en;       // global offset apply
  logic       [5:0] gain_tenths;  // applied gain
  logic       [9:0] offset;       // applied offset
  logic             mismatch;     // copies disagree
  modport cfg (output gain_code, off_prim, off_copy, gain_en, off_en,
               input gain_tenths, offset, mismatch);
  modport app (input gain_code, off_prim, off_copy, gain_en, off_en,
               output gain_tenths, offset, mismatch);
endinterface
`default_nettype wire

// ### hw/cdg_defines.svh
`ifndef CDG_DEFINES_SVH
`define CDG_DEFINES_SVH
// register indices; byte address is four times the index
`define CDG_IDX_CFG3        6'h03
`define CDG_IDX_CH5_PRIM    6'h19
`define CDG_IDX_CH5_COPY    6'h1a
`define CDG_IDX_CH6_PRIM    6'h1b
`define CDG_IDX_CH6_COPY    6'h1c
`define CDG_IDX_CH7_PRIM    6'h1d
`define CDG_IDX_CH7_COPY    6'h1e
`define CDG_IDX_CH8_PRIM    6'h1f
`define CDG_IDX_CH8_COPY    6'h20
`define CDG_IDX_STATUS      6'h3f
// field positions
`define CDG_GAIN_EN_BIT     12
`define CDG_OFFSET_EN_BIT   8
`define CDG_GAIN_MSB        15
`define CDG_GAIN_LSB        11
`define CDG_OFFSET_MSB      9
`define CDG_OFFSET_LSB      0
// gain step in tenths of a decibel (0.2 dB)
`define CDG_GAIN_STEP_TENTHS 2
// reset values
`define CDG_RESET_GAIN      5'h00
`define CDG_RESET_OFFSET    10'h000
`endif

// ### hw/cdg_pkg.sv
package cdg_pkg;
  // result of an address decode
  typedef struct packed {
    logic       hit;   // mapped address
    logic       cfg;   // enable register
    logic       stat;  // status register
    logic       copy;  // offset-only copy register
    logic [1:0] ch;    // channel 5..8 as 0..3
  } cdg_dec_type;

  // register file and bus state of the top module
  typedef struct packed {
    logic [3:0][4:0] gain;      // gain codes
    logic [3:0][9:0] off_prim;  // offset, primary register
    logic [3:0][9:0] off_copy;  // offset, copy register
    logic            gain_en;   // global gain apply
    logic            off_en;    // global offset apply
    logic            pready;    // bus answer
    logic            pslverr;   // bus error
    logic [31:0]     prdata;    // read data
  } cdg_state_type;

  // state of one channel's apply stage
  typedef struct packed {
    logic [5:0] gain_tenths;  // applied gain in 0.1 dB
    logic [9:0] offset;       // applied offset, two's complement
    logic       mismatch;     // offset copies disagree
  } cdg_app_state_type;
endpackage

// ### hw/cdg_top.sv
// The APB interface to the registers was decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "cdg_defines.svh"
// Behaviour
// - gain equals code times 0.2 dB
// - gain applies only with global gain bit
// - offset is ten-bit two's complement
// - offset applies only with global offset bit
// - channels 5..8 decoded at 19h to 20h
// - channel 5 primary register at 19h
// - channel 8 copy register at 20h
module cdg_top (
  input  wire logic        pclk,                // bus clock, 10 MHz
  input  wire logic        presetn,             // async reset, active low
  input  wire logic        psel,                // apb select
  input  wire logic        penable,             // apb access phase
  input  wire logic        pwrite,              // apb write
  input  wire logic [11:0] paddr,               // apb byte address
  input  wire logic [31:0] pwdata,              // apb write data
  input  wire logic [3:0]  pstrb,               // apb byte lanes
  output logic      [31:0] prdata,              // apb read data
  output logic             pready,              // apb ready
  output logic             pslverr,             // apb error
  output logic      [23:0] applied_gain_tenths, // 4 x 6-bit applied gain in 0.1 dB, channel 5 in low bits
  output logic      [39:0] applied_offset,      // 4 x 10-bit fifth_channel_offset_value in low bits
  output logic      [3:0]  copy_mismatch        // per channel copies disagree
);
  cdg_pkg::cdg_state_type state;       // registered state
  cdg_pkg::cdg_state_type next_state;  // next value
  cdg_pkg::cdg_dec_type   dec;         // decode of paddr
  logic                   setup;       // setup phase of a transfer
  logic                   access_done; // completing access phase
  logic [15:0]            rd_word;     // selected read word
  logic [15:0]            wr_mask;     // byte-lane mask for writes
  logic [15:0]            wr_word;     // masked merge of write data

  // maps a register index to its role; word-aligned addresses only
  function automatic cdg_pkg::cdg_dec_type decode(input logic [11:0] addr);
    cdg_pkg::cdg_dec_type d;
    logic [5:0] idx;
    logic [5:0] rel;
    d = '0;
    idx = addr[7:2];
    rel = 6'(idx - `CDG_IDX_CH5_PRIM);
    if (addr[1:0] != 2'h0 || addr[11:8] != 4'h0) begin
      d.hit = 1'b0;
    end else if (idx == `CDG_IDX_CFG3) begin
      d.hit = 1'b1;
      d.cfg = 1'b1;
    end else if (idx == `CDG_IDX_STATUS) begin
      d.hit = 1'b1;
      d.stat = 1'b1;
    end else if (idx >= `CDG_IDX_CH5_PRIM && idx <= `CDG_IDX_CH8_COPY) begin
      // even distance from 19h is a primary, odd is its copy
      d.hit  = 1'b1;
      d.copy = rel[0];
      d.ch   = rel[2:1];
    end
    return d;
  endfunction

  // read word for the current decode
  function automatic logic [15:0] read_word(input cdg_pkg::cdg_state_type s,
                                            input cdg_pkg::cdg_dec_type d,
                                            input logic [3:0] mis);
    logic [15:0] w;
    w = 16'h0000;
    if (d.cfg) begin
      w[`CDG_GAIN_EN_BIT]   = s.gain_en;
      w[`CDG_OFFSET_EN_BIT] = s.off_en;
    end else if (d.stat) begin
      w[3:0] = mis;
    end else if (d.copy) begin
      w[`CDG_OFFSET_MSB:`CDG_OFFSET_LSB] = s.off_copy[d.ch];
    end else begin
      w[`CDG_GAIN_MSB:`CDG_GAIN_LSB]     = s.gain[d.ch];
      w[`CDG_OFFSET_MSB:`CDG_OFFSET_LSB] = s.off_prim[d.ch];
    end
    return w;
  endfunction

  assign dec         = decode(paddr);
  assign setup       = psel && !penable;
  assign access_done = psel && penable && state.pready;
  assign wr_mask     = {{8{pstrb[1]}}, {8{pstrb[0]}}};
  assign rd_word     = read_word(state, dec, copy_mismatch);
  assign wr_word     = (pwdata[15:0] & wr_mask) | (rd_word & ~wr_mask);

  // bus answer and register writes
  always_comb begin
    next_state = state;
    // answer is raised in the first access cycle
    next_state.pready  = setup;
    next_state.pslverr = setup && (!dec.hit || (pwrite && dec.stat));
    if (setup && !pwrite && dec.hit) begin
      next_state.prdata = {16'h0000, rd_word};
    end else if (setup) begin
      next_state.prdata = 32'h0000_0000;
    end
    // a write lands only at the completing edge; reserved bits are dropped
    if (access_done && pwrite && dec.hit) begin
      if (dec.cfg) begin
        // enable register: both global apply bits
        next_state.gain_en = wr_word[`CDG_GAIN_EN_BIT];
        next_state.off_en  = wr_word[`CDG_OFFSET_EN_BIT];
      end else if (dec.copy) begin
        // offset-only copy register; upper bits are not stored
        next_state.off_copy[dec.ch] = wr_word[`CDG_OFFSET_MSB:`CDG_OFFSET_LSB];
      end else if (!dec.stat) begin
        // primary register; status writes never land here
        next_state.gain[dec.ch]     = wr_word[`CDG_GAIN_MSB:`CDG_GAIN_LSB];
        next_state.off_prim[dec.ch] = wr_word[`CDG_OFFSET_MSB:`CDG_OFFSET_LSB];
      end
    end
  end

  // state register; all fields reset to zero
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  assign prdata  = state.prdata;
  assign pready  = state.pready;
  assign pslverr = state.pslverr;

  // one apply stage per channel; the copy check relies on the host
  // keeping both offset copies equal
  generate
    for (genvar c = 0; c < 4; c++) begin : g_chan
      cdg_chan_if u_if ();
      assign u_if.gain_code = state.gain[c];
      assign u_if.off_prim  = state.off_prim[c];
      assign u_if.off_copy  = state.off_copy[c];
      assign u_if.gain_en   = state.gain_en;
      assign u_if.off_en    = state.off_en;
      assign applied_gain_tenths[6*c +: 6] = u_if.gain_tenths;
      assign applied_offset[10*c +: 10]    = u_if.offset;
      assign copy_mismatch[c]              = u_if.mismatch;
      cdg_chan_apply u_apply (
        .pclk    (pclk),
        .presetn (presetn),
        .chan    (u_if)
      );
    end
  endgenerate

  // channel 6 primary at byte 6Ch lands in channel 6 gain
  chk_ch6_decode: assert property (@(posedge pclk) disable iff (!presetn)
    access_done && pwrite && paddr == 12'h06c && pstrb[1]
    |=> state.gain[1] == $past(pwdata[15:11]))
    else $error("channel 6 primary not decoded");
  // channel 5 primary at byte 64h holds gain and offset
  chk_ch5_prim: assert property (@(posedge pclk) disable iff (!presetn)
    access_done && pwrite && paddr == 12'h064 && pstrb == 4'hf
    |=> state.gain[0] == $past(pwdata[15:11]) && state.off_prim[0] == $past(pwdata[9:0]))
    else $error("channel 5 primary not decoded");
  // channel 8 copy at byte 80h
  chk_ch8_copy: assert property (@(posedge pclk) disable iff (!presetn)
    access_done && pwrite && paddr == 12'h080 && pstrb[1:0] == 2'h3
    |=> state.off_copy[3] == $past(pwdata[9:0]))
    else $error("channel 8 copy not decoded");
  // enable write reaches the applied gain two cycles later
  chk_gain_path: assert property (@(posedge pclk) disable iff (!presetn)
    access_done && pwrite && paddr == 12'h00c && pstrb[1] && !pwdata[12]
    |-> ##2 applied_gain_tenths == 24'h000000)
    else $error("gain not cut by enable");
  // every transfer answered in its first access cycle
  chk_bus_ready: assert property (@(posedge pclk) disable iff (!presetn)
    setup |=> pready)
    else $error("no ready in access phase");
  // unmapped address answered with an error
  chk_bus_error: assert property (@(posedge pclk) disable iff (!presetn)
    setup && !dec.hit |=> pslverr)
    else $error("unmapped address not refused");
  cov_ch6_write: cover property (@(posedge pclk) disable iff (!presetn)
    access_done && pwrite && paddr == 12'h06c);
  cov_mismatch: cover property (@(posedge pclk) disable iff (!presetn)
    copy_mismatch != 4'h0);
  cov_status_write: cover property (@(posedge pclk) disable iff (!presetn)
    access_done && pwrite && dec.stat);

  // a refused write leaves every gain and offset register as it was
  chk_err_nowrite: assert property (@(posedge pclk) disable iff (!presetn)
    access_done && pwrite && pslverr
    |=> $stable(state.gain) && $stable(state.off_prim) && $stable(state.off_copy))
    else $error("refused write changed a register");
  // status register is read only
  chk_status_ro: assert property (@(posedge pclk) disable iff (!presetn)
    access_done && pwrite && dec.stat |-> pslverr)
    else $error("status write not refused");
  // answer stands for one cycle only
  chk_ready_pulse: assert property (@(posedge pclk) disable iff (!presetn)
    pready |=> !pready)
    else $error("ready held too long");
  // channel 6 copy at byte 70h
  chk_ch6_copy: assert property (@(posedge pclk) disable iff (!presetn)
    access_done && pwrite && paddr == 12'h070 && pstrb[1:0] == 2'h3
    |=> state.off_copy[1] == $past(pwdata[9:0]))
    else $error("channel 6 copy not decoded");
  // channel 7 primary at byte 74h
  chk_ch7_prim: assert property (@(posedge pclk) disable iff (!presetn)
    access_done && pwrite && paddr == 12'h074 && pstrb == 4'hf
    |=> state.gain[2] == $past(pwdata[15:11]) && state.off_prim[2] == $past(pwdata[9:0]))
    else $error("channel 7 primary not decoded");
  // channel 7 copy at byte 78h
  chk_ch7_copy: assert property (@(posedge pclk) disable iff (!presetn)
    access_done && pwrite && paddr == 12'h078 && pstrb[1:0] == 2'h3
    |=> state.off_copy[2] == $past(pwdata[9:0]))
    else $error("channel 7 copy not decoded");
  // enable bits land where the apply stages read them
  chk_cfg_write: assert property (@(posedge pclk) disable iff (!presetn)
    access_done && pwrite && paddr == 12'h00c && pstrb[1]
    |=> state.gain_en == $past(pwdata[12]) && state.off_en == $past(pwdata[8]))
    else $error("enable bits not stored");
  // primary read returns gain and offset of the decoded channel
  chk_read_prim: assert property (@(posedge pclk) disable iff (!presetn)
    setup && !pwrite && dec.hit && !dec.cfg && !dec.stat && !dec.copy
    |=> prdata[15:11] == $past(state.gain[dec.ch])
        && prdata[9:0] == $past(state.off_prim[dec.ch]))
    else $error("primary read wrong");
  // copy read shows the offset and zeros above it
  chk_read_copy: assert property (@(posedge pclk) disable iff (!presetn)
    setup && !pwrite && dec.copy
    |=> prdata == {22'h0, $past(state.off_copy[dec.ch])})
    else $error("copy read wrong");
  // status read shows the mismatch flags
  chk_read_status: assert property (@(posedge pclk) disable iff (!presetn)
    setup && !pwrite && dec.stat |=> prdata == {28'h0, $past(copy_mismatch)})
    else $error("status read wrong");
endmodule // cdg_top
`default_nettype wire

// ### verification/tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "cdg_defines.svh"
// self-checking bench for the channel gain and offset registers
module tb;
  logic        pclk;          // bus clock
  logic        presetn;       // reset, active low
  logic        psel;          // apb select
  logic        penable;       // apb access phase
  logic        pwrite;        // apb direction
  logic [11:0] paddr;         // byte address
  logic [31:0] pwdata;        // write data
  logic [3:0]  pstrb;         // byte lanes
  logic [31:0] prdata;        // read data
  logic        pready;        // apb ready
  logic        pslverr;       // apb error
  logic [23:0] gain_o;        // applied gains
  logic [39:0] off_o;         // applied offsets
  logic [3:0]  mis_o;         // copy mismatch flags
  int          n_mismatch;    // mismatches seen
  int          total_checks;  // comparisons made
  logic [31:0] rd;            // data of last transfer
  logic        er;            // error of last transfer
  logic [4:0]  gc [4] = '{5'h1f, 5'h00, 5'h01, 5'h10};         // gain codes ch5..ch8
  logic [9:0]  oc [4] = '{10'h200, 10'h1ff, 10'h001, 10'h3ff}; // offsets ch5..ch8

  cdg_top i_cdg_top (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .applied_gain_tenths(gain_o), .applied_offset(off_o),
    .copy_mismatch(mis_o)
  );

  // free-running 10 MHz clock
  always #50 pclk = ~pclk;

  // compare and count
  task automatic check(input logic [39:0] seen, input logic [39:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // report counts and end the run
  task automatic print_verdict;
    $display("checks=%0d mismatches=%0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // byte address of a register index
  function automatic logic [11:0] ba(input logic [5:0] idx);
    return {4'h0, idx, 2'b00};
  endfunction

  // one apb transfer; result left in rd and er
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                     input logic [3:0] s = 4'hf);
    int i;
    // setup starts one edge after any earlier release
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    pstrb   <= s;
    @(posedge pclk);
    penable <= 1'b1;
    // request stands until pready is sampled high at a rising edge
    for (i = 0; i < 16; i++) begin
      @(posedge pclk);
      if (pready === 1'b1) break;
    end
    if (i == 16) begin
      n_mismatch++;
      print_verdict();
    end
    // answer taken at the completing edge, then the bus is released
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  // read a register and compare its data
  task automatic rreg(input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    check(rd, exp);
    check(er, 1'b0);
  endtask

  // wait until applied outputs have followed a write
  task automatic settle;
    repeat (2) @(negedge pclk);
  endtask

  // every channel primary and copy register and every output is zero after reset
  task automatic t_reset;
    for (int c = 0; c < 4; c++) begin
      rreg(ba(6'(`CDG_IDX_CH5_PRIM + 2 * c)), 32'h0);
      rreg(ba(6'(`CDG_IDX_CH5_COPY + 2 * c)), 32'h0);
    end
    check({gain_o, mis_o}, 40'h0);
    check(off_o, 40'h0);
  endtask

  // distinct values per channel catch aliasing between channels; reserved bits read zero
  task automatic t_map;
    for (int c = 0; c < 4; c++) begin
      // host keeps reserved bits zero and both offset copies equal
      apb(1'b1, ba(6'(`CDG_IDX_CH5_PRIM + 2 * c)), {16'h0, gc[c], 1'b0, oc[c]});
      apb(1'b1, ba(6'(`CDG_IDX_CH5_COPY + 2 * c)), {22'h0, oc[c]});
    end
    for (int c = 0; c < 4; c++) begin
      rreg(ba(6'(`CDG_IDX_CH5_PRIM + 2 * c)), {16'h0, gc[c], 1'b0, oc[c]});
      rreg(ba(6'(`CDG_IDX_CH5_COPY + 2 * c)), {22'h0, oc[c]});
    end
    settle();
    check(mis_o, 4'h0);
  endtask

  // global enables gate the gain and the offset independently
  task automatic t_apply;
    logic [23:0] eg;
    eg = '0;
    for (int c = 0; c < 4; c++) eg[c*6 +: 6] = 6'(gc[c]) * 6'd2;
    settle();
    check(gain_o, 24'h0);
    check(off_o, 40'h0);
    apb(1'b1, ba(`CDG_IDX_CFG3), 32'h1000);
    settle();
    check(gain_o, eg);
    check(off_o, 40'h0);
    apb(1'b1, ba(`CDG_IDX_CFG3), 32'h0100);
    settle();
    check(gain_o, 24'h0);
    check(off_o, {oc[3], oc[2], oc[1], oc[0]});
    // both enables on together
    apb(1'b1, ba(`CDG_IDX_CFG3), 32'h1100);
    rreg(ba(`CDG_IDX_CFG3), 32'h1100);
    settle();
    check(gain_o, eg);
    check(off_o, {oc[3], oc[2], oc[1], oc[0]});
  endtask

  // a copy that disagrees is flagged and shown in status
  task automatic t_mis;
    apb(1'b1, ba(`CDG_IDX_CH7_COPY), 32'h0002);
    settle();
    check(mis_o, 4'h4);
    rreg(ba(`CDG_IDX_STATUS), 32'h4);
    apb(1'b1, ba(`CDG_IDX_STATUS), 32'h0);
    check(er, 1'b1);
    apb(1'b1, ba(`CDG_IDX_CH7_COPY), {22'h0, oc[2]});
    settle();
    check(mis_o, 4'h0);
  endtask

  // lane-1 write changes the gain and keeps the low offset byte
  task automatic t_strb;
    apb(1'b1, ba(`CDG_IDX_CH6_PRIM), 32'h0000_a900, 4'h2);
    rreg(ba(`CDG_IDX_CH6_PRIM), 32'h0000_a9ff);
    settle();
    check(gain_o[11:6], 6'h2a);
    apb(1'b1, ba(`CDG_IDX_CH6_PRIM), {16'h0, gc[1], 1'b0, oc[1]});
  endtask

  // unmapped and misaligned addresses are refused and store nothing
  task automatic t_bad;
    apb(1'b1, 12'h084, 32'hffff);
    check(er, 1'b1);
    apb(1'b1, 12'h065, 32'h0);
    check(er, 1'b1);
    apb(1'b1, 12'h164, 32'h0);
    check(er, 1'b1);
    apb(1'b0, 12'h084, 32'h0);
    check(er, 1'b1);
    check(rd, 32'h0);
    rreg(ba(`CDG_IDX_CH5_PRIM), {16'h0, gc[0], 1'b0, oc[0]});
  endtask

  // main sequence
  initial begin
    pclk         = 1'b0;
    presetn      = 1'b0;
    psel         = 1'b0;
    penable      = 1'b0;
    pwrite       = 1'b0;
    paddr        = 12'h000;
    pwdata       = 32'h0;
    pstrb        = 4'h0;
    n_mismatch   = 0;
    total_checks = 0;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_map();
    t_apply();
    t_mis();
    t_strb();
    t_bad();
    print_verdict();
  end
endmodule // tb
`default_nettype wire
